// file: hw/fsrb_pkg.sv
package fsrb_pkg;

  // Register addresses on the serial port
  localparam logic [4:0] ADDR_SUMMARY   = 5'h00;
  localparam logic [4:0] ADDR_OC_DETAIL = 5'h01;
  localparam logic [4:0] ADDR_THERM_OL  = 5'h02;
  localparam logic [4:0] ADDR_CFG_FIRST = 5'h03;
  localparam logic [4:0] ADDR_CFG_LAST  = 5'h09;
  localparam int         NUM_CFG        = 7;

  // Summary register fields
  localparam int SUM_FAULT_BIT = 7;
  localparam int SUM_PROTO_BIT = 6;
  localparam int SUM_UV_BIT    = 5;
  localparam int SUM_PUMP_BIT  = 4;
  localparam int SUM_OC_BIT    = 3;
  localparam int SUM_TF_BIT    = 1;
  localparam int SUM_OL_BIT    = 0;

  // Thermal and open-load detail fields
  localparam int TH_COLD_BIT  = 7;
  localparam int TH_HOT_BIT   = 6;
  localparam int TH_SHUT_BIT  = 5;
  localparam int TH_OLB_BIT   = 1;
  localparam int TH_OLA_BIT   = 0;

  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Config reset values, index 0 is config_reg_a
  localparam logic [NUM_CFG-1:0][7:0] CFG_RESET =
    {8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h0f, 8'h00};
  localparam int CLEAR_CFG_IDX = 3;
  localparam int CLEAR_BIT     = 7;

  // Frame format
  localparam int         FRAME_BITS   = 16;
  localparam int         CMD_READ_BIT = 6;
  localparam logic [1:0] HDR_TAG      = 2'b10;
  localparam logic [1:0] STATUS_TAG   = 2'b11;
  localparam int         HDR_CLR_BIT  = 5;

  // Timing
  localparam int CLK_HZ           = 50_000_000;
  localparam int SCLK_TIMEOUT_NS  = 10_000;
  localparam int SCLK_TIMEOUT_CYC = (SCLK_TIMEOUT_NS / 1000) * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic       supply_uv;
    logic       pump_uv;
    logic [7:0] oc;
    logic       cold;
    logic       hot;
    logic       shutdown;
    logic       ol_b;
    logic       ol_a;
  } fsrb_fault_t;

endpackage

// file: hw/fsrb_sync.sv
`timescale 1ns/10ps
module fsrb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // Two stages; only the second is visible
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

// file: hw/fsrb_bank.sv
`timescale 1ns/10ps
module fsrb_bank
  import fsrb_pkg::*;
#(
  parameter int TIMEOUT_CYC = SCLK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Serial port pins
  input  wire logic                     chip_select_active_low_i,
  input  wire logic                     sclk_i,
  input  wire logic                     sdi_i,
  output logic                          sdo_o,
  output logic                          sdo_oe_o,
  // Sleep pin and protection detectors
  input  wire logic                     sleep_input_active_low_i,
  input  wire fsrb_fault_t              fault_src_i,
  // Fault pin and configuration contents
  output logic                          error_pin_active_low_o,
  output logic [NUM_CFG-1:0][7:0]       cfg_o
);

  fsrb_fault_t             flt_s;
  logic                    cs_n_s;
  logic                    cs_act_s;
  logic                    sclk_s;
  logic                    sdi_s;
  logic                    sleep_n_s;
  logic                    sleep_act_s;
  logic                    sclk_prev_reg;
  logic                    cs_prev_reg;
  logic                    sclk_rise;
  logic                    sclk_fall;
  logic                    cs_fall;
  logic                    cs_rise;
  logic [4:0]              bit_cnt_reg;
  logic [15:0]             rx_reg;
  logic [15:0]             tx_reg;
  logic                    chain_reg;
  logic [15:0]             idle_cnt_reg;
  logic                    stall;
  logic                    bad_len;
  logic                    clear_req;
  logic                    chain_clear;
  logic                    proto_err_reg;
  fsrb_fault_t             latch_reg;
  logic [7:0]              summary;
  logic [7:0]              oc_detail;
  logic [7:0]              therm_detail;
  logic [4:0]              rd_addr;
  logic [7:0]              rd_data;
  logic [4:0]              wr_addr;
  logic                    wr_en;
  logic                    any_fault;

  fsrb_sync #(
    .WIDTH($bits(fsrb_fault_t) + 4)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({fault_src_i, !chip_select_active_low_i, sclk_i, sdi_i,
               !sleep_input_active_low_i}),
    .sync_o  ({flt_s, cs_act_s, sclk_s, sdi_s, sleep_act_s})
  );

  // Select and sleep pass inverted so the synchroniser reset reads as idle, no false edge
  assign cs_n_s    = !cs_act_s;
  assign sleep_n_s = !sleep_act_s;

  // Edge history; reset to idle bus levels
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_n_s;
    end
  end

  assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev_reg;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev_reg;
  assign cs_fall   = !cs_n_s && cs_prev_reg;
  assign cs_rise   = cs_n_s && !cs_prev_reg;

  // Receive: capture on falling edge, count saturates past a full frame
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= '0;
      rx_reg      <= '0;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
    end else if (sclk_fall) begin
      rx_reg <= {rx_reg[14:0], sdi_s};
      if (bit_cnt_reg != 5'h1f) begin
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
      end
    end
  end

  // A frame whose first byte carries the header tag is a chain frame
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chain_reg <= 1'b0;
    end else if (cs_fall) begin
      chain_reg <= 1'b0;
    end else if (sclk_fall && bit_cnt_reg == 5'd7) begin
      chain_reg <= (rx_reg[6:5] == HDR_TAG);
    end
  end

  // Address bits as they stand just before the eighth falling edge
  assign rd_addr = rx_reg[4:0];

  // Transmit: status byte first, then the addressed register; driven on rising edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_reg <= '0;
      sdo_o  <= 1'b0;
    end else if (cs_fall) begin
      tx_reg <= {STATUS_TAG, summary[5:0], 8'h00};
      sdo_o  <= 1'b0;
    end else if (sclk_rise) begin
      sdo_o  <= tx_reg[15];
      tx_reg <= {tx_reg[14:0], 1'b0};
    end else if (sclk_fall && bit_cnt_reg == 5'd7) begin
      // Load before the ninth rise; old contents go out on writes too
      tx_reg[15:8] <= rd_data;
    end
  end

  assign sdo_oe_o = !cs_n_s;

  // Missing clock watchdog; the host must keep clocking while selected
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      idle_cnt_reg <= '0;
    end else if (cs_n_s || sclk_rise || sclk_fall) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != 16'hffff) begin
      idle_cnt_reg <= idle_cnt_reg + 16'd1;
    end
  end

  assign stall   = (idle_cnt_reg == TIMEOUT_CYC[15:0]);
  assign bad_len = cs_rise && !chain_reg && (bit_cnt_reg != FRAME_BITS[4:0]);

  assign chain_clear = cs_rise && chain_reg && (bit_cnt_reg >= FRAME_BITS[4:0]) &&
                       (rx_reg[7:6] == HDR_TAG) && rx_reg[HDR_CLR_BIT];

  // clear via control bit, sleep pulse or chain frame with the clear bit set
  assign clear_req = cfg_o[CLEAR_CFG_IDX][CLEAR_BIT] || !sleep_n_s || chain_clear;

  // error held until frame over and cleared; a new error wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      proto_err_reg <= 1'b0;
    end else if (stall || bad_len) begin
      proto_err_reg <= 1'b1;
    end else if (clear_req && cs_n_s) begin
      proto_err_reg <= 1'b0;
    end
  end

  // status resets to zero
  // Detector faults latch; a clear only drops those no longer asserted
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      latch_reg <= '0;
    end else if (clear_req) begin
      latch_reg <= flt_s;
    end else begin
      latch_reg <= latch_reg | flt_s;
    end
  end

  assign oc_detail = latch_reg.oc;

  // thermal and open-load detail, reserved zero
  always_comb begin
    therm_detail              = STATUS_RESET;
    therm_detail[TH_COLD_BIT] = latch_reg.cold;
    therm_detail[TH_HOT_BIT]  = latch_reg.hot;
    therm_detail[TH_SHUT_BIT] = latch_reg.shutdown;
    therm_detail[TH_OLB_BIT]  = latch_reg.ol_b;
    therm_detail[TH_OLA_BIT]  = latch_reg.ol_a;
  end

  // Warnings alone do not pull the pin
  assign any_fault = proto_err_reg || latch_reg.supply_uv || latch_reg.pump_uv ||
                     (|latch_reg.oc) || latch_reg.shutdown || latch_reg.ol_a ||
                     latch_reg.ol_b;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      error_pin_active_low_o <= 1'b1;
    end else begin
      error_pin_active_low_o <= !any_fault;
    end
  end

  always_comb begin
    summary                = STATUS_RESET;
    summary[SUM_FAULT_BIT] = !error_pin_active_low_o;
    summary[SUM_PROTO_BIT] = proto_err_reg;
    summary[SUM_UV_BIT]    = latch_reg.supply_uv;
    summary[SUM_PUMP_BIT]  = latch_reg.pump_uv;
    summary[SUM_OC_BIT]    = |oc_detail;
    summary[SUM_OL_BIT]    = therm_detail[TH_OLB_BIT] | therm_detail[TH_OLA_BIT];
    summary[SUM_TF_BIT]    = therm_detail[TH_COLD_BIT] | therm_detail[TH_HOT_BIT] |
                             therm_detail[TH_SHUT_BIT];
  end

  // read decode; unlisted addresses read zero
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr == ADDR_SUMMARY) begin
      rd_data = summary;
    end else if (rd_addr == ADDR_OC_DETAIL) begin
      rd_data = oc_detail;
    end else if (rd_addr == ADDR_THERM_OL) begin
      rd_data = therm_detail;
    end else if (rd_addr >= ADDR_CFG_FIRST && rd_addr <= ADDR_CFG_LAST) begin
      rd_data = cfg_o[3'(rd_addr - ADDR_CFG_FIRST)];
    end
  end

  // writes only reach the config range
  assign wr_addr = rx_reg[13:9];
  assign wr_en   = cs_rise && !chain_reg && (bit_cnt_reg == FRAME_BITS[4:0]) &&
                   !rx_reg[15] && !rx_reg[CMD_READ_BIT + 8] &&
                   wr_addr >= ADDR_CFG_FIRST && wr_addr <= ADDR_CFG_LAST;

  // config registers; clear bit drops itself after one cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_o <= CFG_RESET;
    end else begin
      cfg_o[CLEAR_CFG_IDX][CLEAR_BIT] <= 1'b0;
      if (wr_en) begin
        cfg_o[3'(wr_addr - ADDR_CFG_FIRST)] <= rx_reg[7:0];
      end
    end
  end

endmodule

// file: test/fsrb_bank_chk.sv
`timescale 1ns/10ps
module fsrb_chk
  import fsrb_pkg::*;
#(
  parameter int TIMEOUT_CYC = SCLK_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_n_i,
  // Watched pins
  input wire logic                    chip_select_active_low_i,
  input wire logic                    sclk_i,
  input wire logic                    sdo_o,
  input wire logic                    sdo_oe_o,
  input wire fsrb_fault_t             fault_src_i,
  input wire logic                    error_pin_active_low_o,
  input wire logic [NUM_CFG-1:0][7:0] cfg_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  int   idle_q;
  logic sclk_q;
  // Saturates so a long stall cannot wrap back under the limit
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk_i;
    if (!rst_n_i || chip_select_active_low_i || sclk_i != sclk_q) begin
      idle_q <= 0;
    end else if (idle_q < 1000) begin
      idle_q <= idle_q + 1;
    end
  end
  sequence s_uv;
    fault_src_i.supply_uv [*4];
  endsequence
  sequence s_oc;
    (|fault_src_i.oc) [*4];
  endsequence
  sequence s_ol;
    (fault_src_i.ol_a || fault_src_i.ol_b) [*4];
  endsequence
  a_uv_pulls_pin: assert property (s_uv |-> ##[0:2] !error_pin_active_low_o)
    else $error("pin high under undervoltage");
  a_oc_pulls_pin: assert property (s_oc |-> ##[0:2] !error_pin_active_low_o)
    else $error("pin high under overcurrent");
  a_ol_pulls_pin: assert property (s_ol |-> ##[0:2] !error_pin_active_low_o)
    else $error("pin high under open load");
  a_stall_err_pin: assert property (idle_q >= TIMEOUT_CYC + 8 |-> !error_pin_active_low_o)
    else $error("stalled clock not flagged");
  a_pin_reset_high: assert property ($rose(rst_n_i) |-> error_pin_active_low_o)
    else $error("pin low after reset");
  a_cfg_reset_val: assert property ($rose(rst_n_i) |-> cfg_o == CFG_RESET)
    else $error("config not at reset value");
  a_cfg_idle_hold: assert property (chip_select_active_low_i [*8] |-> $stable(cfg_o))
    else $error("config moved outside a frame");
  a_oe_idle_low: assert property (chip_select_active_low_i [*4] |-> !sdo_oe_o)
    else $error("data out driven while deselected");
  a_oe_frame_high: assert property (!chip_select_active_low_i [*4] |-> sdo_oe_o)
    else $error("data out not driven in frame");
  a_sdo_hold_low: assert property
    ((!sclk_i && !chip_select_active_low_i) [*6] |-> $stable(sdo_o))
    else $error("data out moved with clock low");
endmodule

bind fsrb_bank fsrb_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) fsrb_chk_inst (.clk_i, .rst_n_i,
  .chip_select_active_low_i, .sclk_i, .sdo_o, .sdo_oe_o, .fault_src_i,
  .error_pin_active_low_o, .cfg_o);

// file: test/fsrb_host.sv
`timescale 1ns/10ps
module fsrb_host (
  // Clock
  input  wire logic   clk_i,
  // Serial pins
  output logic        cs_n_o,
  output logic        sclk_o,
  output logic        sdi_o,
  input  wire logic   sdo_i,
  // Received frame
  output logic        done_o,
  output logic [15:0] rx_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    done_o = 1'b0;
    rx_o = 16'h0000;
  end
  task automatic xfer(input logic [16:0] tx, input int nb, input int hp, input logic chk);
    logic [15:0] rx;
    rx = 16'h0000;
    cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = nb - 1; i >= 0; i--) begin
      sdi_o = tx[i];
      sclk_o = 1'b1;
      repeat (hp) @(negedge clk_i);
      rx = {rx[14:0], sdo_i};
      sclk_o = 1'b0;
      repeat (hp) @(negedge clk_i);
    end
    // Zero bits means a select held low with a dead clock
    if (nb == 0) repeat (hp) @(negedge clk_i);
    cs_n_o = 1'b1;
    // Idle data line wanders so nothing can lean on its last level
    sdi_o = ~sdi_o;
    rx_o = rx;
    done_o = chk;
    @(negedge clk_i);
    done_o = 1'b0;
    repeat (5) @(negedge clk_i);
  endtask
endmodule

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
  import fsrb_pkg::*;
  localparam int TMO = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slp_n = 1'b1;
  fsrb_fault_t flt = '0;
  logic cs_n, sclk, sdi, sdo, sdo_oe, pin_n, done;
  logic [15:0] rx;
  logic [NUM_CFG-1:0][7:0] cfg;
  logic [15:0] exp_q[$];
  logic [7:0] shadow[NUM_CFG];
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 32'hc1d8;
  always #10 clk_i = ~clk_i;
  fsrb_bank #(.TIMEOUT_CYC(TMO)) fsrb_bank_inst (.clk_i, .rst_n_i,
    .chip_select_active_low_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .sleep_input_active_low_i(slp_n), .fault_src_i(flt),
    .error_pin_active_low_o(pin_n), .cfg_o(cfg));
  fsrb_host fsrb_host_inst (.clk_i, .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
    .sdo_i(sdo), .done_o(done), .rx_o(rx));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] sum_of(input fsrb_fault_t f, input logic perr);
    logic p;
    p = perr | f.supply_uv | f.pump_uv | (|f.oc) | f.shutdown | f.ol_b | f.ol_a;
    return {p, perr, f.supply_uv, f.pump_uv, |f.oc, 1'b0, f.cold | f.hot | f.shutdown,
            f.ol_b | f.ol_a};
  endfunction
  // Reply is noted before the frame, prompt or slow clock at random
  task automatic acc(input logic rd, input logic [4:0] a, input logic [7:0] d,
                     input logic [7:0] s, input logic [7:0] old);
    exp_q.push_back({2'b11, s[5:0], old});
    fsrb_host_inst.xfer({2'b00, rd, a, 1'b0, d}, 16, ($random(seed) & 1) ? 9 : 5, 1'b1);
  endtask
  task automatic clr(input int how, input logic [7:0] s);
    if (how == 0) begin
      acc(0, ADDR_CFG_FIRST + 5'(CLEAR_CFG_IDX), shadow[CLEAR_CFG_IDX] | 8'h80, s,
          shadow[CLEAR_CFG_IDX]);
    end else if (how == 1) begin
      slp_n = 1'b0;
      repeat (6) @(negedge clk_i);
      slp_n = 1'b1;
      repeat (6) @(negedge clk_i);
    end else begin
      fsrb_host_inst.xfer({1'b0, 16'ha0a0}, 16, 5, 1'b0);
    end
  endtask
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      chk(rx, exp_q.pop_front());
    end
    cyc++;
    if (cyc > 60000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    fsrb_fault_t f;
    logic [7:0] s, v;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    for (int a = 0; a < 3; a++) acc(1, 5'(a), 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < NUM_CFG; i++) begin
      shadow[i] = CFG_RESET[i];
      acc(1, ADDR_CFG_FIRST + 5'(i), 8'h00, 8'h00, CFG_RESET[i]);
    end
    acc(1, 5'h0a, 8'h00, 8'h00, 8'h00);
    acc(1, 5'h1f, 8'h00, 8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < NUM_CFG; i++) begin
      v = 8'($random(seed));
      if (i == CLEAR_CFG_IDX) v[CLEAR_BIT] = 1'b0;
      acc(0, ADDR_CFG_FIRST + 5'(i), v, 8'h00, shadow[i]);
      chk({8'h00, cfg[i]}, {8'h00, v});
      shadow[i] = v;
      acc(1, ADDR_CFG_FIRST + 5'(i), 8'h00, 8'h00, v);
    end
    $display("test config done");
    for (int k = 0; k < 6; k++) begin
      f = 15'($random(seed));
      flt = f;
      repeat (8) @(negedge clk_i);
      s = sum_of(f, 1'b0);
      chk({15'h0000, pin_n}, {15'h0000, ~s[7]});
      acc(1, ADDR_SUMMARY, 8'h00, s, s);
      acc(1, ADDR_OC_DETAIL, 8'h00, s, f.oc);
      acc(1, ADDR_THERM_OL, 8'h00, s, {f.cold, f.hot, f.shutdown, 3'b000, f.ol_b, f.ol_a});
      acc(0, ADDR_SUMMARY, 8'hff, s, s);
      acc(0, ADDR_OC_DETAIL, ~f.oc, s, f.oc);
      flt = '0;
      repeat (8) @(negedge clk_i);
      acc(1, ADDR_OC_DETAIL, 8'h00, s, f.oc);
      clr(k % 3, s);
      acc(1, ADDR_SUMMARY, 8'h00, 8'h00, 8'h00);
    end
    $display("test faults done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) fsrb_host_inst.xfer(17'h1ffff, 17, 5, 1'b0);
      else fsrb_host_inst.xfer(17'h00000, 0, TMO + 20, 1'b0);
      acc(1, ADDR_SUMMARY, 8'h00, 8'h00, 8'hc0);
      clr(k, 8'h00);
      acc(1, ADDR_SUMMARY, 8'h00, 8'h00, 8'h00);
    end
    $display("test protocol done");
    finish_test();
  end
endmodule
